/* shared/speed_map_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SPEED_MAP_CFG_SVH
`define SPEED_MAP_CFG_SVH
`define IDX_CTRL 4'd0
`define IDX_SPEED_CMD 4'd1
`define IDX_THRESH 4'd2
`define IDX_FREQ_CFG 4'd3
`define IDX_POINTS0 4'd4
`define IDX_POINTS1 4'd5
`define IDX_POINTS2 4'd6
`define IDX_LEVELS0 4'd7
`define IDX_LEVELS1 4'd8
`define IDX_LEVELS2 4'd9
`define IDX_SCALE 4'd10
`define IDX_STATUS 4'd11
`define IDX_TARGET 4'd12
`define NUM_CFG 11
`define CTRL_SRC_LSB 0
`define CTRL_PROF_LSB 2
`define CTRL_LOOP_OFF_BIT 4
`define CTRL_DIR_BIT 5
`define SRC_REGISTER 2'b10
`define SRC_FREQUENCY 2'b11
`define PROF_DIRECT 2'b00
`define PROF_LINEAR 2'b01
`define PROF_STAIR 2'b10
`define PROF_FWD_REV 2'b11
`define CFG_RESET 32'h0000_0000
`define FULL_DUTY 8'hff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CLK_HZ 25000000
`define SLEEP_ENTRY_US 1000
`define SLEEP_ENTRY_CYC (`SLEEP_ENTRY_US * (`CLK_HZ / 1000000))
`define FREQ_GATE_US 10000
`define FREQ_GATE_CYC (`FREQ_GATE_US * (`CLK_HZ / 1000000))
`define FREQ_GATE_HZ (1000000 / `FREQ_GATE_US)
`endif

/* shared/speed_map_pkg.sv */
// Types shared by the speed reference mapper
package speed_map_pkg;
    typedef enum logic [1:0] {PWR_RUN, PWR_STANDBY, PWR_SLEEP} pwr_state_t;
    // Transfer curve: duty breakpoints and their levels
    typedef struct packed {
        logic [7:0] low_off_point;
        logic [7:0] low_on_point;
        logic [7:0] low_clamp_point;
        logic [7:0] pt_a;
        logic [7:0] pt_b;
        logic [7:0] pt_c;
        logic [7:0] pt_d;
        logic [7:0] pt_e;
        logic [7:0] high_clamp_point;
        logic [7:0] high_on_point;
        logic [7:0] high_off_point;
        logic [7:0] low_off_level;
        logic [7:0] low_clamp_level;
        logic [7:0] lv_a;
        logic [7:0] lv_b;
        logic [7:0] lv_c;
        logic [7:0] lv_d;
        logic [7:0] lv_e;
        logic [7:0] high_clamp_level;
        logic [7:0] high_off_level;
    } curve_t;
    // Result handed to the control loop
    typedef struct packed {
        logic [15:0] speed_target;
        logic [15:0] current_target;
        logic        reverse;
        logic        stop;
    } target_t;
endpackage : speed_map_pkg

/* tb/speed_map_monitor.sv */
// Handshake and power-state checks on the mapper ports
`timescale 1ns/100ps
module speed_map_monitor (
    input wire logic        aclk, aresetn, awvalid, awready, wvalid, wready,
    input wire logic        bvalid, bready, arvalid, arready, rvalid, rready,
    input wire logic [1:0]  bresp,
    input wire logic [31:0] rdata,
    input wire speed_map_pkg::target_t target,
    input wire logic        sleep, standby
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read answer comes next edge and stands
    AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
    AST_R_STAND: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("rdata moved");
    AST_AR_BLOCK: assert property (rvalid |-> !arready) else $error("read taken while busy");
    // Write response stands, readies drop meanwhile
    AST_B_STAND: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("bresp moved");
    AST_B_BLOCK: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
    AST_AW_TAKE: assert property (awvalid && awready |=> !awready) else $error("awready stuck");
    // Idle states exclude each other and stop the motor
    AST_PWR_EXCL: assert property (standby |-> !sleep) else $error("sleep and standby");
    AST_IDLE_STOP: assert property (sleep || standby |-> ##[0:2] target.stop) else $error("not stopped");
endmodule : speed_map_monitor

/* tb/speed_src_model.sv */
// Square wave source feeding the speed pin
`timescale 1ns/100ps
module speed_src_model (
    input  wire logic       aclk,
    input  wire logic       run,
    input  wire logic [3:0] half,
    output logic            pin
);
    logic [3:0] cnt_ff;
    // Held low when stopped, so no stray edges reach the counter
    always_ff @(posedge aclk)
    begin
        cnt_ff <= (!run || cnt_ff + 4'h1 >= half) ? 4'h0 : cnt_ff + 4'h1;
        pin    <= !run ? 1'b0 : (cnt_ff + 4'h1 >= half) ? !pin : pin;
    end
endmodule : speed_src_model

/* tb/tb_top.sv */
// Self-checking bench for the speed reference mapper
`timescale 1ns/100ps
module tb_top;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, speed_pin, dir_pin, run;
    logic        awready, wready, bvalid, arready, rvalid, sleep, standby;
    logic [7:0]  awaddr, araddr, speed_level, ext_duty, cmd;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb, half;
    logic [1:0]  bresp, rresp, rs;
    logic [15:0] sfs, cfs;
    speed_map_pkg::target_t target;
    int          n_fail = 0;
    int          n_checks = 0;
    speed_reference_profile_mapper #(.SLEEP_CYC(20), .GATE_CYC(100)) u_dut (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .speed_pin, .speed_level, .ext_duty, .dir_pin, .target, .sleep, .standby);
    speed_src_model u_src (.aclk, .run, .half, .pin(speed_pin));
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    // One bus transfer; each channel dropped at its own handshake edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (w ? bvalid : rvalid) break;
        end
        rd = rdata;
        rs = w ? bresp : rresp;
        {bready, rready} <= 2'b00;
        if (i == 50)
        begin
            n_fail++;
            test_done;
        end
    endtask : xfer
    // Write, then let duty and target settle
    task automatic wt(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        repeat (4) @(posedge aclk);
    endtask : wt
    function automatic logic [31:0] stair(input logic [7:0] d);
        return d <= 8'h0a ? 32'h0a : d <= 8'h14 ? 32'h1e : d <= 8'h28 ? 32'h32 : d <= 8'h3c ? 32'h46 :
               d <= 8'h50 ? 32'h5a : d <= 8'h64 ? 32'h6e : 32'h82;
    endfunction : stair
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // Watchdog: a hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge aclk);
        n_fail++;
        test_done;
    end
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, dir_pin, run} = 8'h00;
        {awaddr, araddr, speed_level, ext_duty, wdata, wstrb, half} = {64'h0, 4'hf, 4'h2};
        repeat (12) @(posedge aclk);
        void'($urandom(7));
        aresetn <= 1'b1;
        ext_duty <= 8'($urandom);
        sfs = 16'($urandom);
        cfs = 16'($urandom);
        cmd = 8'd30 + 8'($urandom % 200);
        // Direct profile from the host register, hysteresis 10
        xfer(1'b1, 8'h28, {cfs, sfs});
        xfer(1'b1, 8'h08, 32'hff00_000a);
        xfer(1'b1, 8'h00, 32'h02);
        wt(8'h04, cmd);
        chk("spd", target.speed_target, cmd * sfs / 255);
        xfer(1'b0, 8'h04, 32'h0);
        chk("cmd", rd, cmd);
        wt(8'h04, cmd + 8'h5);
        chk("hys", target.speed_target, cmd * sfs / 255);
        wt(8'h00, 32'h12);
        chk("cur", target.current_target, cmd * cfs / 255);
        wt(8'h04, 32'h0);
        chk("zero", target.stop, 1'b1);
        xfer(1'b0, 8'h34, 32'h0);
        chk("unmap", {rs, rd[29:0]}, {2'b10, 30'h0});
        xfer(1'b1, 8'h30, 32'h1);
        chk("ro", rs, 2'b10);
        // Standby and sleep thresholds in register mode
        speed_level <= 8'hc8;
        xfer(1'b1, 8'h08, 32'h6432_1400);
        wt(8'h04, 32'h10);
        chk("sb", standby, 1'b1);
        wt(8'h04, 32'h30);
        chk("sb_off", standby, 1'b0);
        speed_level <= 8'h10;
        wt(8'h04, 32'h0);
        repeat (40) @(posedge aclk);
        chk("slp", sleep, 1'b1);
        speed_level <= 8'hc8;
        repeat (4) @(posedge aclk);
        chk("wake", sleep, 1'b0);
        // Staircase, unit scale; first field of a word sits in its top byte; ascending
        xfer(1'b1, 8'h08, 32'hff00_0000);
        xfer(1'b1, 8'h28, 32'h00ff_00ff);
        xfer(1'b1, 8'h10, 32'h0204_0a14);
        xfer(1'b1, 8'h14, 32'h283c_5064);
        xfer(1'b1, 8'h18, 32'h0078_c8dc);
        xfer(1'b1, 8'h1c, 32'h000a_1e32);
        xfer(1'b1, 8'h20, 32'h465a_6e82);
        xfer(1'b1, 8'h00, 32'h0a);
        for (int k = 0; k < 8; k++)
        begin
            cmd = 8'd12 + 8'($urandom % 108);
            wt(8'h04, cmd);
            chk("stair", target.speed_target, stair(cmd));
        end
        // Forward-reverse with both direction inputs asserted
        dir_pin <= 1'b1;
        wt(8'h00, 32'h2e);
        wt(8'h04, 32'h5a);
        chk("rev", target.reverse, 1'b1);
        wt(8'h04, 32'h1e);
        chk("fwd", target.reverse, 1'b0);
        // Frequency mode, full scale 1000 Hz
        xfer(1'b1, 8'h0c, 32'h0000_03e8);
        xfer(1'b1, 8'h00, 32'h03);
        half <= 4'h1 + 4'($urandom % 3);
        run <= 1'b1;
        repeat (300) @(posedge aclk);
        xfer(1'b0, 8'h2c, 32'h0);
        chk("fmax", rd[7:0], 8'hff);
        run <= 1'b0;
        repeat (300) @(posedge aclk);
        xfer(1'b0, 8'h2c, 32'h0);
        chk("fzero", {rd[9], rd[7:0]}, 9'h100);
        test_done;
    end
endmodule : tb_top
bind speed_reference_profile_mapper speed_map_monitor u_mon (.aclk, .aresetn, .awvalid, .awready, .wvalid,
    .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .bresp, .rdata, .target, .sleep, .standby);

/* verilog/speed_reference_profile_mapper.sv */
// Speed command source selection, duty normalisation and transfer profiles
//
// Overview of operation
// - Source select 10b takes the duty command from the host speed register.
// - Register mode: sleep when pin below entry level after zero command held long.
// - Register mode: leave sleep when pin above exit level, use host register.
// - Register mode: standby while command at or below threshold and pin above exit.
// - Source select 11b: duty command linear in measured speed pin frequency.
// - Frequency mode: duty zero and motor stopped at or below standby frequency.
// - Frequency mode: duty clamps to full scale above full-scale frequency.
// - Profile 00b: target is duty times speed or current full scale.
// - Profile 00b: duty changes smaller than the hysteresis leave target unchanged.
// - A zero command from any source stops the motor in every profile.
// - Shaped profiles scale level by level/255 times the selected full scale.
// - Profile 01b: piecewise-linear through low clamp, points A to E, high clamp.
// - Low-off and high-off levels with on/off hysteresis at both ends.
// - Linear: hold low clamp level to its duty, separate slope per segment.
// - Profile 10b: staircase, one step at each breakpoint duty.
// - Staircase steps to A at low clamp duty, next level at previous point.
// - Profile 11b: direction reverses when duty crosses breakpoint C.
// - Forward-reverse ignores the direction pin and the direction register bit.
// - Forward-reverse: A between A and B, idle from B to D, reverse D, ramp past E.
// - Forward-reverse: high clamp level changes to high-off level above high-off duty.
// - Loop-off bit clear selects speed target, set selects current target.
`timescale 1ns/100ps
`include "speed_map_cfg.svh"

module speed_reference_profile_mapper #(
    parameter int SLEEP_CYC = `SLEEP_ENTRY_CYC,
    parameter int GATE_CYC  = `FREQ_GATE_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        speed_pin,
    input  wire logic [7:0]  speed_level,
    input  wire logic [7:0]  ext_duty,
    input  wire logic        dir_pin,
    output speed_map_pkg::target_t target,
    output logic             sleep,
    output logic             standby
);
    // Register storage and bus state
    logic [31:0]               cfg_ff [`NUM_CFG];
    logic                      aw_got_ff;
    logic                      w_got_ff;
    logic [3:0]                aw_idx_ff;
    logic [31:0]               w_data_ff;
    logic [3:0]                w_strb_ff;
    logic                      bvalid_ff;
    logic [1:0]                bresp_ff;
    logic                      rvalid_ff;
    logic [31:0]               rdata_ff;
    logic [1:0]                rresp_ff;
    // Datapath state
    logic                      pin_prev_ff;
    logic [31:0]               gate_cnt_ff;
    logic [15:0]               edge_cnt_ff;
    logic [15:0]               freq_hz_ff;
    logic [31:0]               zero_cnt_ff;
    speed_map_pkg::pwr_state_t pwr_ff;
    logic [7:0]                duty_ff;
    logic                      zero_cmd_ff;
    logic [7:0]                hold_ff;
    logic                      low_off_ff;
    logic                      high_off_ff;
    speed_map_pkg::target_t    target_ff;
    // Combinational
    speed_map_pkg::curve_t     cv;
    logic [1:0]                src;
    logic [1:0]                prof;
    logic                      loop_off;
    logic [7:0]                cmd_reg;
    logic [7:0]                nxt_duty;
    logic                      nxt_zero;
    logic [15:0]               fs_freq;
    logic [15:0]               sb_freq;
    logic [7:0]                level;
    logic                      rev;
    logic                      idle;
    logic [7:0]                diff;
    logic [7:0]                eff_duty;
    logic                      zero_long;
    speed_map_pkg::target_t    nxt_target;
    logic [31:0]               rd_word;
    logic                      rd_ok;

    assign src      = cfg_ff[`IDX_CTRL][`CTRL_SRC_LSB +: 2];
    assign prof     = cfg_ff[`IDX_CTRL][`CTRL_PROF_LSB +: 2];
    assign loop_off = cfg_ff[`IDX_CTRL][`CTRL_LOOP_OFF_BIT];
    assign cmd_reg  = cfg_ff[`IDX_SPEED_CMD][7:0];
    assign fs_freq  = cfg_ff[`IDX_FREQ_CFG][15:0];
    assign sb_freq  = cfg_ff[`IDX_FREQ_CFG][31:16];
    assign cv = {cfg_ff[`IDX_POINTS0], cfg_ff[`IDX_POINTS1], cfg_ff[`IDX_POINTS2][23:0],
                 cfg_ff[`IDX_LEVELS0], cfg_ff[`IDX_LEVELS1], cfg_ff[`IDX_LEVELS2][7:0]};

    // Straight line between two breakpoints, clipped to the byte range
    function automatic logic [7:0] interp(input logic [7:0] d, input logic [7:0] d0,
                                          input logic [7:0] l0, input logic [7:0] d1,
                                          input logic [7:0] l1);
        logic signed [17:0] num;
        logic signed [17:0] q;
        num = 18'(signed'({1'b0, l1}) - signed'({1'b0, l0})) * 18'(d - d0);
        q = (d1 == d0) ? 18'sd0 : num / 18'(signed'({1'b0, d1 - d0}));
        q = q + 18'(l0);
        interp = (q < 0) ? 8'h00 : ((q > 255) ? 8'hff : q[7:0]);
    endfunction : interp

    // Merge a write under byte strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        for (int i = 0; i < 4; i++)
        begin
            merge[8*i +: 8] = st[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge

    // Write channels taken in either order, answered once both are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            aw_idx_ff <= 4'h0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= `RESP_OKAY;
        end
        else
        begin
            if (awvalid && !aw_got_ff && !bvalid_ff)
            begin
                aw_got_ff <= 1'b1;
                aw_idx_ff <= awaddr[5:2];
                if (awaddr[7:6] != 2'b00)
                    aw_idx_ff <= 4'hf; // Out of the map
            end
            if (wvalid && !w_got_ff && !bvalid_ff)
            begin
                w_got_ff  <= 1'b1;
                w_data_ff <= wdata;
                w_strb_ff <= wstrb;
            end
            if (aw_got_ff && w_got_ff && !bvalid_ff)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= (aw_idx_ff < 4'(`NUM_CFG)) ? `RESP_OKAY : `RESP_SLVERR;
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
            end
            if (bvalid_ff && bready)
                bvalid_ff <= 1'b0;
        end
    end

    // Configuration registers; status words are read only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (int i = 0; i < `NUM_CFG; i++)
                cfg_ff[i] <= `CFG_RESET;
        end
        else if (aw_got_ff && w_got_ff && !bvalid_ff && aw_idx_ff < 4'(`NUM_CFG))
        begin
            cfg_ff[aw_idx_ff] <= merge(cfg_ff[aw_idx_ff], w_data_ff, w_strb_ff);
        end
    end

    // Read decode
    always_comb
    begin
        rd_ok = (araddr[7:6] == 2'b00) && (araddr[5:2] <= `IDX_TARGET);
        rd_word = 32'h0000_0000;
        if (araddr[5:2] == `IDX_STATUS)
            rd_word = {freq_hz_ff, 4'h0, 2'(pwr_ff), target_ff.stop, target_ff.reverse, duty_ff};
        else if (araddr[5:2] == `IDX_TARGET)
            rd_word = {target_ff.current_target, target_ff.speed_target};
        else if (araddr[5:2] < 4'(`NUM_CFG))
            rd_word = cfg_ff[araddr[5:2]];
    end

    // Read channel: one cycle from address to data
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `RESP_OKAY;
        end
        else if (arvalid && !rvalid_ff)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rd_ok ? rd_word : 32'h0000_0000;
            rresp_ff  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (rvalid_ff && rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // Frequency counter over a fixed gate; long gate trades latency for resolution
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_prev_ff <= 1'b0;
            gate_cnt_ff <= 32'h0000_0000;
            edge_cnt_ff <= 16'h0000;
            freq_hz_ff  <= 16'h0000;
        end
        else
        begin
            pin_prev_ff <= speed_pin;
            if (gate_cnt_ff >= 32'(GATE_CYC - 1))
            begin
                gate_cnt_ff <= 32'h0000_0000;
                freq_hz_ff  <= 16'(edge_cnt_ff * 16'(`FREQ_GATE_HZ));
                edge_cnt_ff <= 16'h0000;
            end
            else
            begin
                gate_cnt_ff <= gate_cnt_ff + 32'h0000_0001;
                if (speed_pin && !pin_prev_ff && edge_cnt_ff != 16'hffff)
                    edge_cnt_ff <= edge_cnt_ff + 16'h0001;
            end
        end
    end

    // Source selection and normalisation to a duty command
    always_comb
    begin
        nxt_duty = ext_duty;
        nxt_zero = (ext_duty == 8'h00);
        if (src == `SRC_REGISTER)
        begin
            nxt_duty = cmd_reg;
            nxt_zero = (cmd_reg == 8'h00);
        end
        else if (src == `SRC_FREQUENCY)
        begin
            nxt_zero = (freq_hz_ff == 16'h0000);
            if (freq_hz_ff <= sb_freq)
                nxt_duty = 8'h00;
            else if (freq_hz_ff > fs_freq || fs_freq == 16'h0000)
                nxt_duty = `FULL_DUTY;
            else
                nxt_duty = 8'((24'(freq_hz_ff) * 24'd255) / 24'(fs_freq));
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            duty_ff     <= 8'h00;
            zero_cmd_ff <= 1'b1;
        end
        else
        begin
            duty_ff     <= nxt_duty;
            zero_cmd_ff <= nxt_zero || nxt_duty == 8'h00;
        end
    end

    // Time the host command has stayed at zero, saturating
    assign zero_long = zero_cnt_ff > 32'(SLEEP_CYC);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            zero_cnt_ff <= 32'h0000_0000;
        else if (cmd_reg != 8'h00)
            zero_cnt_ff <= 32'h0000_0000;
        else if (!zero_long)
            zero_cnt_ff <= zero_cnt_ff + 32'h0000_0001;
    end

    // Sleep and standby, only for the register source
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pwr_ff <= speed_map_pkg::PWR_RUN;
        else if (src != `SRC_REGISTER)
            pwr_ff <= speed_map_pkg::PWR_RUN;
        else
        begin
            case (pwr_ff)
                speed_map_pkg::PWR_SLEEP:
                    if (speed_level > cfg_ff[`IDX_THRESH][31:24])
                        pwr_ff <= speed_map_pkg::PWR_RUN;
                speed_map_pkg::PWR_RUN, speed_map_pkg::PWR_STANDBY:
                    if (zero_long && speed_level < cfg_ff[`IDX_THRESH][23:16])
                        pwr_ff <= speed_map_pkg::PWR_SLEEP;
                    else if (cmd_reg <= cfg_ff[`IDX_THRESH][15:8]
                             && speed_level > cfg_ff[`IDX_THRESH][31:24])
                        pwr_ff <= speed_map_pkg::PWR_STANDBY;
                    else
                        pwr_ff <= speed_map_pkg::PWR_RUN;
                default:
                    pwr_ff <= speed_map_pkg::PWR_RUN;
            endcase
        end
    end

    // Hysteresis hold for the direct profile; zero passes at once
    assign diff = (duty_ff > hold_ff) ? duty_ff - hold_ff : hold_ff - duty_ff;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hold_ff <= 8'h00;
        else if (diff >= cfg_ff[`IDX_THRESH][7:0] || duty_ff == 8'h00)
            hold_ff <= duty_ff;
    end

    // Off-region flags at both ends; between on and off points the flag keeps
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_off_ff  <= 1'b1;
            high_off_ff <= 1'b0;
        end
        else
        begin
            if (duty_ff < cv.low_off_point)
                low_off_ff <= 1'b1;
            else if (duty_ff >= cv.low_on_point)
                low_off_ff <= 1'b0;
            if (duty_ff > cv.high_off_point)
                high_off_ff <= 1'b1;
            else if (duty_ff <= cv.high_on_point)
                high_off_ff <= 1'b0;
        end
    end

    // Profile level on the 0..255 scale; breakpoints assumed ascending
    always_comb
    begin
        eff_duty = duty_ff;
        idle = 1'b0;
        rev = cfg_ff[`IDX_CTRL][`CTRL_DIR_BIT] | dir_pin;
        level = cv.high_clamp_level;
        case (prof)
            `PROF_DIRECT:
                level = hold_ff;
            `PROF_LINEAR:
                if (eff_duty <= cv.low_clamp_point)
                    level = cv.low_clamp_level;
                else if (eff_duty <= cv.pt_a)
                    level = interp(eff_duty, cv.low_clamp_point, cv.low_clamp_level,
                                   cv.pt_a, cv.lv_a);
                else if (eff_duty <= cv.pt_b)
                    level = interp(eff_duty, cv.pt_a, cv.lv_a, cv.pt_b, cv.lv_b);
                else if (eff_duty <= cv.pt_c)
                    level = interp(eff_duty, cv.pt_b, cv.lv_b, cv.pt_c, cv.lv_c);
                else if (eff_duty <= cv.pt_d)
                    level = interp(eff_duty, cv.pt_c, cv.lv_c, cv.pt_d, cv.lv_d);
                else if (eff_duty <= cv.pt_e)
                    level = interp(eff_duty, cv.pt_d, cv.lv_d, cv.pt_e, cv.lv_e);
                else if (eff_duty <= cv.high_clamp_point)
                    level = interp(eff_duty, cv.pt_e, cv.lv_e,
                                   cv.high_clamp_point, cv.high_clamp_level);
            `PROF_STAIR:
                if (eff_duty <= cv.low_clamp_point)
                    level = cv.low_clamp_level;
                else if (eff_duty <= cv.pt_a)
                    level = cv.lv_a;
                else if (eff_duty <= cv.pt_b)
                    level = cv.lv_b;
                else if (eff_duty <= cv.pt_c)
                    level = cv.lv_c;
                else if (eff_duty <= cv.pt_d)
                    level = cv.lv_d;
                else if (eff_duty <= cv.pt_e)
                    level = cv.lv_e;
            `PROF_FWD_REV:
            begin
                rev = eff_duty > cv.pt_c;
                if (eff_duty <= cv.low_clamp_point)
                    level = cv.low_clamp_level;
                else if (eff_duty <= cv.pt_a)
                    level = interp(eff_duty, cv.low_clamp_point, cv.low_clamp_level,
                                   cv.pt_a, cv.lv_a);
                else if (eff_duty <= cv.pt_b)
                    level = cv.lv_a;
                else if (eff_duty <= cv.pt_d)
                    idle = 1'b1;
                else if (eff_duty <= cv.pt_e)
                    level = cv.lv_d;
                else if (eff_duty <= cv.high_clamp_point)
                    level = interp(eff_duty, cv.pt_e, cv.lv_d,
                                   cv.high_clamp_point, cv.high_clamp_level);
            end
            default:
                level = 8'h00;
        endcase
        // End regions override the shaped curve
        if (prof != `PROF_DIRECT && low_off_ff)
            level = cv.low_off_level;
        else if (prof != `PROF_DIRECT && high_off_ff)
            level = cv.high_off_level;
    end

    // Scale to the selected full scale and register for the control loop
    always_comb
    begin
        nxt_target = '0;
        nxt_target.reverse = rev;
        nxt_target.stop = zero_cmd_ff || idle || pwr_ff != speed_map_pkg::PWR_RUN;
        if (!nxt_target.stop)
        begin
            if (!loop_off)
                nxt_target.speed_target = 16'((24'(level) * 24'(cfg_ff[`IDX_SCALE][15:0]))
                                               / 24'd255);
            else
                nxt_target.current_target = 16'((24'(level) * 24'(cfg_ff[`IDX_SCALE][31:16]))
                                                 / 24'd255);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            target_ff <= '{speed_target: 16'h0000, current_target: 16'h0000,
                           reverse: 1'b0, stop: 1'b1};
        end
        else
        begin
            target_ff <= nxt_target;
        end
    end

    // Outputs from flip-flops; readies, sleep and standby decoded from flip-flops
    assign awready = !aw_got_ff && !bvalid_ff;
    assign wready  = !w_got_ff && !bvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = !rvalid_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = rdata_ff;
    assign rresp   = rresp_ff;
    assign target  = target_ff;
    assign sleep   = (pwr_ff == speed_map_pkg::PWR_SLEEP);
    assign standby = (pwr_ff == speed_map_pkg::PWR_STANDBY);
endmodule : speed_reference_profile_mapper
